// >>> include/sps_pkg.sv
// shared constants of the setup parameter store
package sps_pkg;
	// clock and time base
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
	// hold and timeout times in milliseconds
	localparam int unsigned MENU_HOLD_MS = 5000;
	localparam int unsigned CAL_HOLD_MS = 3000;
	localparam int unsigned CAL_EDIT_MS = 10000;
	localparam int unsigned EXIT_HOLD_MS = 3000;
	localparam int unsigned IDLE_MS = 5000;
	localparam int unsigned MS_W = 14;

	// register byte addresses
	localparam logic [7:0] A_SETPOINT = 8'h00;
	localparam logic [7:0] A_LOW_LIM = 8'h04;
	localparam logic [7:0] A_HIGH_LIM = 8'h08;
	localparam logic [7:0] A_BG_REF = 8'h0c;
	localparam logic [7:0] A_BARO = 8'h10;
	localparam logic [7:0] A_TEMP_OFS = 8'h14;
	localparam logic [7:0] A_CO2_OFS = 8'h18;
	localparam logic [7:0] A_SERIAL = 8'h1c;
	localparam logic [7:0] A_CONTROL = 8'h20;
	localparam logic [7:0] A_STATUS = 8'h24;
	localparam logic [7:0] A_TEMP_DISP = 8'h28;
	localparam logic [7:0] A_CO2_DISP = 8'h2c;

	// serial register fields
	localparam int unsigned SER_AUTO_BIT = 0;
	localparam int unsigned SER_PARITY_LSB = 1;
	localparam int unsigned SER_BAUD_LSB = 3;
	localparam int unsigned SER_STOP_BIT = 6;
	// control register fields
	localparam int unsigned CTL_FRESET_BIT = 0;
	localparam int unsigned CTL_CAL_EDIT_BIT = 1;

	// limits and defaults (temperatures whole degC, offset in 0.1 degC)
	localparam logic signed [15:0] SP_DEF = 16'sh0015;
	localparam logic signed [15:0] LOW_DEF = 16'sh0014;
	localparam logic signed [15:0] LOW_MIN = 16'sh0000;
	localparam logic signed [15:0] HIGH_DEF = 16'sh0023;
	localparam logic signed [15:0] HIGH_MAX = 16'sh0032;
	localparam logic signed [15:0] BG_DEF = 16'sh0190;
	localparam logic signed [15:0] BG_MIN = 16'sh00c8;
	localparam logic signed [15:0] BG_MAX = 16'sh270f;
	localparam logic signed [15:0] BARO_DEF = 16'sh03f5;
	localparam logic signed [15:0] BARO_MIN = 16'sh02a5;
	localparam logic signed [15:0] BARO_MAX = 16'sh03f8;
	localparam logic signed [15:0] TOFS_LIM = 16'sh012c;
	localparam logic signed [15:0] COFS_LIM = 16'sh01f4;
	localparam logic [15:0] SER_DEF = 16'h0001;

	typedef enum logic [1:0] {
		PARITY_NONE = 2'h0, PARITY_EVEN = 2'h1, PARITY_ODD = 2'h2
	} sps_parity_t;
	typedef enum logic [2:0] {
		BAUD_9600 = 3'h0, BAUD_19200 = 3'h1, BAUD_38400 = 3'h2,
		BAUD_57600 = 3'h3, BAUD_76800 = 3'h4, BAUD_115200 = 3'h5
	} sps_baud_t;

	// non-volatile image layout
	localparam int unsigned NV_DEPTH = 16;
	localparam int unsigned NV_AW = 4;
	localparam logic [3:0] NV_SIG = 4'h0;
	localparam logic [3:0] NV_SP = 4'h1;
	localparam logic [3:0] NV_LOW = 4'h2;
	localparam logic [3:0] NV_HIGH = 4'h3;
	localparam logic [3:0] NV_BG = 4'h4;
	localparam logic [3:0] NV_BARO = 4'h5;
	localparam logic [3:0] NV_TOFS = 4'h6;
	localparam logic [3:0] NV_COFS = 4'h7;
	localparam logic [3:0] NV_SER = 4'h8;
	localparam logic [15:0] NV_SIG_VAL = 16'h5a3c;

	typedef enum logic [1:0] {
		ST_BOOT = 2'h0, ST_LOAD = 2'h1, ST_RUN = 2'h3, ST_FRST = 2'h2
	} sps_state_t;
endpackage

// >>> include/sps_nv_if.sv
// port between the parameter logic and its storage image
`timescale 1ns/1ps
interface sps_nv_if;
	logic we;
	logic [3:0] waddr;
	logic [15:0] wdata;
	logic [3:0] raddr;
	logic [15:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> design/sps_nv_mem.sv
// parameter image storage with registered read data
`timescale 1ns/1ps
module sps_nv_mem #(
	parameter int unsigned DEPTH = sps_pkg::NV_DEPTH
) (
	// clock
	input wire logic clk_sys,
	// access port
	sps_nv_if.mem nv
);
	// not reset: contents must survive an ordinary restart
	logic [15:0] mem_r [DEPTH];
	logic [15:0] rdata_r;

	always_ff @(posedge clk_sys) begin
		if (nv.we) begin
			mem_r[nv.waddr] <= nv.wdata;
		end
		rdata_r <= mem_r[nv.raddr];
	end

	assign nv.rdata = rdata_r;
endmodule

// >>> design/sps_param_store.sv
// setup parameter store: limits, calibration, offsets, serial setup, buttons
`timescale 1ns/1ps
module sps_param_store #(
	parameter int unsigned TICK_CYC = sps_pkg::TICK_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// front-panel buttons
	input wire logic btn_up,
	input wire logic btn_down,
	// raw measurements (temperature in 0.1 degC)
	input wire logic signed [15:0] raw_temp,
	input wire logic signed [15:0] raw_co2,
	// parameter outputs
	output logic [15:0] setpoint,
	output logic [15:0] setpoint_low_limit,
	output logic [15:0] setpoint_high_limit,
	output logic [15:0] background_cal_reference,
	output logic [15:0] baro_hpa,
	output logic [15:0] temp_display,
	output logic [15:0] co2_display,
	// serial line setup
	output logic autobaud_en,
	output logic [1:0] parity_select,
	output logic [2:0] baud_select,
	output logic stop_bit_select,
	output logic manual_serial_visible,
	// user interface state
	output logic setpoint_screen,
	output logic menu_open,
	output logic cal_start,
	output logic cal_dashes,
	output logic device_restart,
	output logic ready
);
	localparam int unsigned TW = $clog2(TICK_CYC + 1);

	sps_nv_if nv ();

	sps_nv_mem #(.DEPTH(sps_pkg::NV_DEPTH)) u_mem (
		.clk_sys(clk_sys),
		.nv(nv.mem)
	);

	// millisecond enable
	logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		tick_nxt = (tick_cnt_r == TW'(TICK_CYC - 1));
		tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + TW'(1);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	function automatic logic [15:0] nv_default(input logic [3:0] idx);
		case (idx)
			sps_pkg::NV_SP: nv_default = sps_pkg::SP_DEF;
			sps_pkg::NV_LOW: nv_default = sps_pkg::LOW_DEF;
			sps_pkg::NV_HIGH: nv_default = sps_pkg::HIGH_DEF;
			sps_pkg::NV_BG: nv_default = sps_pkg::BG_DEF;
			sps_pkg::NV_BARO: nv_default = sps_pkg::BARO_DEF;
			sps_pkg::NV_SER: nv_default = sps_pkg::SER_DEF;
			sps_pkg::NV_SIG: nv_default = sps_pkg::NV_SIG_VAL;
			default: nv_default = 16'h0000;
		endcase
	endfunction

	// parameter and interface state
	sps_pkg::sps_state_t st_r, st_nxt;
	logic [3:0] idx_r, idx_nxt, rd_idx_r;
	logic signed [15:0] sp_r, sp_nxt, low_r, low_nxt, high_r, high_nxt;
	logic signed [15:0] bg_r, bg_nxt, baro_r, baro_nxt, tofs_r, tofs_nxt, cofs_r, cofs_nxt;
	logic [15:0] ser_r, ser_nxt, rdata_r, rdata_nxt;
	logic sp_pend_r, sp_pend_nxt, menu_r, menu_nxt, cal_edit_r, cal_edit_nxt;
	logic dash_r, dash_nxt, cal_start_r, cal_start_nxt, restart_r, restart_nxt;
	logic sp_scr_r, sp_scr_nxt, up_q_r, dn_q_r, ready_r, vis_r;
	logic [sps_pkg::MS_W-1:0] both_ms_r, both_ms_nxt, dn_ms_r, dn_ms_nxt;
	logic [sps_pkg::MS_W-1:0] cal_ms_r, cal_ms_nxt, idle_ms_r, idle_ms_nxt;
	logic signed [15:0] temp_d_r, co2_d_r;
	logic signed [15:0] w;
	logic bus_we;

	assign w = $signed(reg_wdata);
	assign bus_we = reg_wr && (st_r == sps_pkg::ST_RUN);
	assign nv.raddr = idx_r;

	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		sp_nxt = sp_r;
		low_nxt = low_r;
		high_nxt = high_r;
		bg_nxt = bg_r;
		baro_nxt = baro_r;
		tofs_nxt = tofs_r;
		cofs_nxt = cofs_r;
		ser_nxt = ser_r;
		sp_pend_nxt = sp_pend_r;
		menu_nxt = menu_r;
		cal_edit_nxt = cal_edit_r;
		dash_nxt = dash_r;
		cal_start_nxt = 1'b0;
		restart_nxt = 1'b0;
		sp_scr_nxt = sp_scr_r;
		both_ms_nxt = both_ms_r;
		dn_ms_nxt = dn_ms_r;
		cal_ms_nxt = cal_ms_r;
		idle_ms_nxt = idle_ms_r;
		nv.we = 1'b0;
		nv.waddr = sps_pkg::NV_SIG;
		nv.wdata = 16'h0000;
		case (st_r)
			sps_pkg::ST_BOOT: begin
				idx_nxt = 4'h1;
				st_nxt = sps_pkg::ST_LOAD;
			end
			sps_pkg::ST_LOAD: begin
				idx_nxt = idx_r + 4'h1;
				case (rd_idx_r)
					// blank or damaged image falls back to defaults
					// unknown contents must also take the default path
					sps_pkg::NV_SIG: begin
						if (nv.rdata == sps_pkg::NV_SIG_VAL) begin
							st_nxt = sps_pkg::ST_LOAD;
						end else begin
							idx_nxt = 4'h1;
							st_nxt = sps_pkg::ST_FRST;
						end
					end
					sps_pkg::NV_SP: sp_nxt = nv.rdata;
					sps_pkg::NV_LOW: low_nxt = nv.rdata;
					sps_pkg::NV_HIGH: high_nxt = nv.rdata;
					sps_pkg::NV_BG: bg_nxt = nv.rdata;
					sps_pkg::NV_BARO: baro_nxt = nv.rdata;
					sps_pkg::NV_TOFS: tofs_nxt = nv.rdata;
					sps_pkg::NV_COFS: cofs_nxt = nv.rdata;
					sps_pkg::NV_SER: begin
						ser_nxt = nv.rdata;
						st_nxt = sps_pkg::ST_RUN;
					end
					default: ;
				endcase
			end
			sps_pkg::ST_FRST: begin
				// signature written last so an interrupted reset repeats
				nv.we = 1'b1;
				nv.waddr = idx_r;
				nv.wdata = nv_default(idx_r);
				if (idx_r == sps_pkg::NV_SIG) begin
					restart_nxt = 1'b1;
					st_nxt = sps_pkg::ST_BOOT;
					menu_nxt = 1'b0;
					cal_edit_nxt = 1'b0;
					dash_nxt = 1'b0;
					sp_scr_nxt = 1'b0;
					sp_pend_nxt = 1'b0;
				end
				idx_nxt = (idx_r == sps_pkg::NV_SER) ? sps_pkg::NV_SIG : idx_r + 4'h1;
			end
			sps_pkg::ST_RUN: begin
				if (bus_we) begin
					case (reg_addr)
						sps_pkg::A_SETPOINT: if (w >= low_r && w <= high_r) begin
							sp_nxt = w;
							sp_pend_nxt = 1'b1;
						end
						sps_pkg::A_LOW_LIM: if (w >= sps_pkg::LOW_MIN && w <= high_r) begin
							low_nxt = w;
							nv.we = 1'b1;
							nv.waddr = sps_pkg::NV_LOW;
							if (w > sp_r) begin
								sp_nxt = w;
								sp_pend_nxt = 1'b1;
							end
						end
						sps_pkg::A_HIGH_LIM: if (w >= low_r && w <= sps_pkg::HIGH_MAX) begin
							high_nxt = w;
							nv.we = 1'b1;
							nv.waddr = sps_pkg::NV_HIGH;
							if (w < sp_r) begin
								sp_nxt = w;
								sp_pend_nxt = 1'b1;
							end
						end
						sps_pkg::A_BG_REF: if (w >= sps_pkg::BG_MIN && w <= sps_pkg::BG_MAX) begin
							bg_nxt = w;
							nv.we = 1'b1;
							nv.waddr = sps_pkg::NV_BG;
						end
						sps_pkg::A_BARO: if (w >= sps_pkg::BARO_MIN && w <= sps_pkg::BARO_MAX) begin
							baro_nxt = w;
							nv.we = 1'b1;
							nv.waddr = sps_pkg::NV_BARO;
						end
						sps_pkg::A_TEMP_OFS: if (w >= -sps_pkg::TOFS_LIM && w <= sps_pkg::TOFS_LIM) begin
							tofs_nxt = w;
							nv.we = 1'b1;
							nv.waddr = sps_pkg::NV_TOFS;
						end
						sps_pkg::A_CO2_OFS: if (w >= -sps_pkg::COFS_LIM && w <= sps_pkg::COFS_LIM) begin
							cofs_nxt = w;
							nv.we = 1'b1;
							nv.waddr = sps_pkg::NV_COFS;
						end
						sps_pkg::A_SERIAL: begin
							// unlisted parity or baud codes refuse the whole write
							if (reg_wdata[sps_pkg::SER_PARITY_LSB +: 2] <= 2'(sps_pkg::PARITY_ODD)
								&& reg_wdata[sps_pkg::SER_BAUD_LSB +: 3] <= 3'(sps_pkg::BAUD_115200)) begin
								ser_nxt = {9'h000, reg_wdata[6:0]};
								nv.we = 1'b1;
								nv.waddr = sps_pkg::NV_SER;
							end
						end
						sps_pkg::A_CONTROL: begin
							if (reg_wdata[sps_pkg::CTL_FRESET_BIT]) begin
								idx_nxt = 4'h1;
								st_nxt = sps_pkg::ST_FRST;
							end else if (reg_wdata[sps_pkg::CTL_CAL_EDIT_BIT] && menu_r) begin
								cal_edit_nxt = 1'b1;
							end
						end
						default: ;
					endcase
					nv.wdata = reg_wdata;
				end else if (sp_pend_r && !sp_scr_r) begin
					nv.we = 1'b1;
					nv.waddr = sps_pkg::NV_SP;
					nv.wdata = sp_r;
					sp_pend_nxt = 1'b0;
				end
				// both buttons held opens the menu
				if (btn_up && btn_down) begin
					if (tick_r && both_ms_r != sps_pkg::MS_W'(sps_pkg::MENU_HOLD_MS)) begin
						both_ms_nxt = both_ms_r + sps_pkg::MS_W'(1);
						if (both_ms_r == sps_pkg::MS_W'(sps_pkg::MENU_HOLD_MS - 1)) begin
							menu_nxt = 1'b1;
							sp_scr_nxt = 1'b0;
						end
					end
				end else begin
					both_ms_nxt = '0;
				end
				// down alone held: start calibration or leave the menu
				if (btn_down && !btn_up && menu_r) begin
					if (tick_r && dn_ms_r != sps_pkg::MS_W'(sps_pkg::CAL_HOLD_MS)) begin
						dn_ms_nxt = dn_ms_r + sps_pkg::MS_W'(1);
						if (dn_ms_r == sps_pkg::MS_W'(sps_pkg::CAL_HOLD_MS - 1)) begin
							if (cal_edit_r && !dash_r) begin
								cal_start_nxt = 1'b1;
								dash_nxt = 1'b1;
								cal_ms_nxt = '0;
							end else if (!cal_edit_r) begin
								menu_nxt = 1'b0;
							end
						end
					end
				end else begin
					dn_ms_nxt = '0;
				end
				if (dash_r && tick_r) begin
					cal_ms_nxt = cal_ms_r + sps_pkg::MS_W'(1);
					if (cal_ms_r == sps_pkg::MS_W'(sps_pkg::CAL_EDIT_MS - 1)) begin
						dash_nxt = 1'b0;
						cal_edit_nxt = 1'b0;
					end
				end
				// set point screen from single presses outside the menu
				if (!menu_r && (btn_up ^ btn_down) && !(up_q_r | dn_q_r)) begin
					idle_ms_nxt = '0;
					if (!sp_scr_r) begin
						sp_scr_nxt = 1'b1;
					end else if (btn_up && sp_r < high_r) begin
						sp_nxt = sp_r + 16'sh0001;
					end else if (btn_down && sp_r > low_r) begin
						sp_nxt = sp_r - 16'sh0001;
					end
				end else if (btn_up || btn_down) begin
					idle_ms_nxt = '0;
				end else if (sp_scr_r && tick_r) begin
					idle_ms_nxt = idle_ms_r + sps_pkg::MS_W'(1);
					if (idle_ms_r == sps_pkg::MS_W'(sps_pkg::IDLE_MS - 1)) begin
						sp_scr_nxt = 1'b0;
						sp_pend_nxt = 1'b1;
					end
				end
			end
			default: st_nxt = sps_pkg::ST_BOOT;
		endcase
	end

	// read data, one cycle after the strobe
	always_comb begin
		rdata_nxt = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				sps_pkg::A_SETPOINT: rdata_nxt = sp_r;
				sps_pkg::A_LOW_LIM: rdata_nxt = low_r;
				sps_pkg::A_HIGH_LIM: rdata_nxt = high_r;
				sps_pkg::A_BG_REF: rdata_nxt = bg_r;
				sps_pkg::A_BARO: rdata_nxt = baro_r;
				sps_pkg::A_TEMP_OFS: rdata_nxt = tofs_r;
				sps_pkg::A_CO2_OFS: rdata_nxt = cofs_r;
				sps_pkg::A_SERIAL: rdata_nxt = ser_r;
				sps_pkg::A_STATUS: rdata_nxt = {8'h00, menu_r, cal_edit_r, dash_r, sp_scr_r,
					!ser_r[sps_pkg::SER_AUTO_BIT], sp_pend_r, st_r};
				sps_pkg::A_TEMP_DISP: rdata_nxt = temp_d_r;
				sps_pkg::A_CO2_DISP: rdata_nxt = co2_d_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= sps_pkg::ST_BOOT;
			idx_r <= 4'h0;
			rd_idx_r <= 4'h0;
			sp_r <= sps_pkg::SP_DEF;
			low_r <= sps_pkg::LOW_DEF;
			high_r <= sps_pkg::HIGH_DEF;
			bg_r <= sps_pkg::BG_DEF;
			baro_r <= sps_pkg::BARO_DEF;
			tofs_r <= 16'sh0000;
			cofs_r <= 16'sh0000;
			ser_r <= sps_pkg::SER_DEF;
			rdata_r <= 16'h0000;
			{sp_pend_r, menu_r, cal_edit_r, dash_r, cal_start_r, restart_r} <= 6'h00;
			{sp_scr_r, up_q_r, dn_q_r} <= 3'h0;
			ready_r <= 1'b0;
			vis_r <= ~sps_pkg::SER_DEF[sps_pkg::SER_AUTO_BIT];
			{both_ms_r, dn_ms_r, cal_ms_r, idle_ms_r} <= '0;
			temp_d_r <= 16'sh0000;
			co2_d_r <= 16'sh0000;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			rd_idx_r <= idx_r;
			sp_r <= sp_nxt;
			low_r <= low_nxt;
			high_r <= high_nxt;
			bg_r <= bg_nxt;
			baro_r <= baro_nxt;
			tofs_r <= tofs_nxt;
			cofs_r <= cofs_nxt;
			ser_r <= ser_nxt;
			rdata_r <= rdata_nxt;
			{sp_pend_r, menu_r, cal_edit_r} <= {sp_pend_nxt, menu_nxt, cal_edit_nxt};
			{dash_r, cal_start_r, restart_r} <= {dash_nxt, cal_start_nxt, restart_nxt};
			{sp_scr_r, up_q_r, dn_q_r} <= {sp_scr_nxt, btn_up, btn_down};
			ready_r <= (st_nxt == sps_pkg::ST_RUN);
			vis_r <= ~ser_nxt[sps_pkg::SER_AUTO_BIT];
			{both_ms_r, dn_ms_r} <= {both_ms_nxt, dn_ms_nxt};
			{cal_ms_r, idle_ms_r} <= {cal_ms_nxt, idle_ms_nxt};
			// only the stored offsets reach the shown readings
			temp_d_r <= raw_temp + tofs_r;
			co2_d_r <= raw_co2 + cofs_r;
		end
	end

	assign reg_rdata = rdata_r;
	assign setpoint = sp_r;
	assign setpoint_low_limit = low_r;
	assign setpoint_high_limit = high_r;
	assign background_cal_reference = bg_r;
	assign baro_hpa = baro_r;
	assign temp_display = temp_d_r;
	assign co2_display = co2_d_r;
	assign autobaud_en = ser_r[sps_pkg::SER_AUTO_BIT];
	assign parity_select = ser_r[sps_pkg::SER_PARITY_LSB +: 2];
	assign baud_select = ser_r[sps_pkg::SER_BAUD_LSB +: 3];
	assign stop_bit_select = ser_r[sps_pkg::SER_STOP_BIT];
	// manual fields shown only with auto serial off
	assign manual_serial_visible = vis_r;
	assign setpoint_screen = sp_scr_r;
	assign menu_open = menu_r;
	assign cal_start = cal_start_r;
	assign cal_dashes = dash_r;
	assign device_restart = restart_r;
	assign ready = ready_r;
endmodule

// >>> test/sps_param_store_chk.sv
// concurrent checks on the setup parameter store ports
`timescale 1ns/1ps
module sps_param_store_chk #(
	parameter int unsigned TICK_CYC = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port and buttons
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic btn_up,
	input wire logic btn_down,
	// parameters
	input wire logic [15:0] setpoint,
	input wire logic [15:0] setpoint_low_limit,
	input wire logic [15:0] setpoint_high_limit,
	input wire logic [15:0] background_cal_reference,
	input wire logic [15:0] baro_hpa,
	// serial setup
	input wire logic autobaud_en,
	input wire logic [1:0] parity_select,
	input wire logic [2:0] baud_select,
	input wire logic manual_serial_visible,
	// user interface state
	input wire logic setpoint_screen,
	input wire logic menu_open,
	input wire logic cal_start,
	input wire logic cal_dashes,
	input wire logic device_restart,
	input wire logic ready
);
	logic signed [15:0] wd_s;
	logic signed [15:0] lo_s;
	logic signed [15:0] hi_s;
	logic signed [15:0] sp_s;
	assign wd_s = reg_wdata;
	assign lo_s = setpoint_low_limit;
	assign hi_s = setpoint_high_limit;
	assign sp_s = setpoint;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_high_clamp_sp: assert property (ready && reg_wr && reg_addr == sps_pkg::A_HIGH_LIM
		&& wd_s >= lo_s && wd_s <= 16'sh0032 && wd_s < sp_s |=> setpoint == $past(reg_wdata)
		&& setpoint_high_limit == $past(reg_wdata)) else $error("set point not pulled down");
	a_low_clamp_sp: assert property (ready && reg_wr && reg_addr == sps_pkg::A_LOW_LIM
		&& wd_s >= 16'sh0000 && wd_s <= hi_s && wd_s > sp_s
		|=> setpoint == $past(reg_wdata)) else $error("set point not pulled up");
	a_sp_window: assert property (ready |-> sp_s >= lo_s && sp_s <= hi_s)
		else $error("set point outside its limits");
	a_high_range: assert property (ready |-> hi_s <= 16'sh0032 && hi_s >= lo_s)
		else $error("high limit out of range");
	a_bg_ref_range: assert property (ready |-> background_cal_reference >= 16'h00c8
		&& background_cal_reference <= 16'h270f) else $error("reference out of range");
	a_baro_range: assert property (ready |-> baro_hpa >= 16'h02a5 && baro_hpa <= 16'h03f8)
		else $error("pressure out of range");
	a_serial_codes: assert property (parity_select != 2'h3 && baud_select <= 3'h5)
		else $error("illegal serial code");
	a_manual_shown: assert property (manual_serial_visible == !autobaud_en)
		else $error("manual serial visibility wrong");
	a_cal_dash_start: assert property (cal_start |-> cal_dashes ##1 (cal_dashes && !cal_start))
		else $error("calibration start without dashes");
	a_cal_down_held: assert property (cal_start |-> $past(btn_down) && !$past(btn_up))
		else $error("calibration started without down hold");
	a_menu_both_held: assert property ($rose(menu_open) |-> $past(btn_up) && $past(btn_down))
		else $error("menu opened without both buttons");
	a_restart_pulse: assert property (device_restart |=> !device_restart && !ready)
		else $error("restart not a single pulse");

	c_cal: cover property (cal_start);
	c_restart: cover property (device_restart);
	c_menu: cover property ($rose(menu_open));
	c_sp_save: cover property ($fell(setpoint_screen));
endmodule

bind sps_param_store sps_param_store_chk #(.TICK_CYC(TICK_CYC)) u_chk (.clk_sys, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .btn_up, .btn_down, .setpoint, .setpoint_low_limit,
	.setpoint_high_limit, .background_cal_reference, .baro_hpa, .autobaud_en, .parity_select,
	.baud_select, .manual_serial_visible, .setpoint_screen, .menu_open, .cal_start, .cal_dashes,
	.device_restart, .ready);

// >>> test/sps_param_store_tb_top.sv
// self-checking bench for the setup parameter store
`timescale 1ns/1ps
module sps_param_store_tb_top;
	logic clk_sys, rst_n, reg_wr, reg_rd, btn_up, btn_down, autobaud_en, stop_bit_select;
	logic manual_serial_visible, setpoint_screen, menu_open, cal_start, cal_dashes;
	logic device_restart, ready;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, setpoint, setpoint_low_limit, setpoint_high_limit;
	logic [15:0] background_cal_reference, baro_hpa, temp_display, co2_display, sv;
	logic signed [15:0] raw_temp, raw_co2;
	logic [1:0] parity_select;
	logic [2:0] baud_select;
	logic [15:0] exp_q[$];
	logic [15:0] mdl[0:7];
	logic [15:0] rv[0:15] = '{16'h00c7, 16'h00c8, 16'h270f, 16'h2710, 16'h02a4, 16'h02a5,
		16'h03f9, 16'h03f8, 16'hfed3, 16'hfed4, 16'h012d, 16'h012c, 16'hfe0b, 16'h01f4,
		16'h01f5, 16'hfe0c};
	logic [15:0] okm = 16'haaa6;
	logic rd_d = 1'b0;
	int fail_count = 0;
	int check_count = 0;
	int seed = 81429;
	int n;

	// 2-cycle tick keeps the second-long holds short
	sps_param_store #(.TICK_CYC(2)) dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .btn_up, .btn_down, .raw_temp, .raw_co2, .setpoint,
		.setpoint_low_limit, .setpoint_high_limit, .background_cal_reference, .baro_hpa,
		.temp_display, .co2_display, .autobaud_en, .parity_select, .baud_select,
		.stop_bit_select, .manual_serial_visible, .setpoint_screen, .menu_open, .cal_start,
		.cal_dashes, .device_restart, .ready);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_rd(input logic [15:0] got);
		if (exp_q.size() == 0) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, 16'h0000);
		end else begin
			chk_val(got, exp_q.pop_front());
		end
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rd_d) begin
			chk_rd(reg_rdata);
		end
		rd_d <= reg_rd;
	end

	// trailing idle cycle keeps strobes from being driven twice in one step
	task wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	endtask

	task rd_all();
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4), mdl[i]);
		end
		rd(8'h3c, 16'h0000);
	endtask

	task set_defaults();
		mdl = '{sps_pkg::SP_DEF, sps_pkg::LOW_DEF, sps_pkg::HIGH_DEF, sps_pkg::BG_DEF,
			sps_pkg::BARO_DEF, 16'h0000, 16'h0000, sps_pkg::SER_DEF};
	endtask

	task try(input int i, input logic [15:0] v, input logic ok);
		wr(8'(i * 4), v);
		if (ok) begin
			mdl[i] = v;
		end
		rd(8'(i * 4), mdl[i]);
	endtask

	function logic sel(input int w);
		case (w)
			0: return ready;
			1: return menu_open;
			2: return cal_start;
			3: return cal_dashes;
			4: return device_restart;
			default: return setpoint_screen;
		endcase
	endfunction

	// looks at negedges so one-cycle pulses are seen settled
	task wait_on(input int w, input logic lvl, input int lim);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
			if (n > lim) begin
				chk_val(16'(n), 16'(lim));
				stop_test();
			end
		end while (sel(w) !== lvl);
		@(posedge clk_sys);
	endtask

	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		btn_up = 1'b0;
		btn_down = 1'b0;
		raw_temp = 16'sh0000;
		raw_co2 = 16'sh0000;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_on(0, 1'b1, 200);
		set_defaults();
		rd_all();
		$display("defaults done");
		try(2, 16'h0014, 1'b1);
		mdl[0] = 16'h0014;
		rd(8'h00, mdl[0]);
		try(2, 16'h0013, 1'b0);
		try(2, 16'h0033, 1'b0);
		try(2, 16'h0032, 1'b1);
		try(0, 16'h0016, 1'b1);
		try(1, 16'h001e, 1'b1);
		mdl[0] = 16'h001e;
		rd(8'h00, mdl[0]);
		try(1, 16'h0033, 1'b0);
		try(1, 16'h0000, 1'b1);
		$display("limits done");
		for (int k = 0; k < 16; k++) begin
			try(3 + k / 4, rv[k], okm[k]);
		end
		for (int k = 0; k < 8; k++) begin
			raw_temp <= 16'($random(seed) % 700);
			raw_co2 <= 16'($random(seed) % 3000);
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk_val(temp_display, raw_temp + mdl[5]);
			chk_val(co2_display, raw_co2 + mdl[6]);
			@(posedge clk_sys);
			rd(sps_pkg::A_CO2_DISP, raw_co2 + mdl[6]);
			rd(sps_pkg::A_TEMP_DISP, raw_temp + mdl[5]);
		end
		chk_val(background_cal_reference, mdl[3]);
		chk_val(baro_hpa, mdl[4]);
		$display("ranges done");
		for (int p = 0; p < 4; p++) begin
			for (int b = 0; b < 8; b++) begin
				sv = {9'h000, b[0], b[2:0], p[1:0], b[1]};
				try(7, sv, p < 3 && b < 6);
				@(negedge clk_sys);
				chk_val({9'h000, stop_bit_select, baud_select, parity_select, autobaud_en},
					mdl[7]);
				chk_val({15'h0, manual_serial_visible}, {15'h0, ~mdl[7][0]});
				@(posedge clk_sys);
			end
		end
		$display("serial done");
		wr(sps_pkg::A_CONTROL, 16'h0001);
		wait_on(4, 1'b1, 100);
		wait_on(0, 1'b1, 100);
		set_defaults();
		rd_all();
		$display("factory reset done");
		for (int k = 0; k < 2; k++) begin
			btn_up <= 1'b1;
			repeat (2) @(posedge clk_sys);
			btn_up <= 1'b0;
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk_val({15'h0, setpoint_screen}, 16'h0001);
			@(posedge clk_sys);
		end
		chk_val(setpoint, 16'h0016);
		wait_on(5, 1'b0, 10100);
		chk_val(16'(n > 9900), 16'h0001);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_on(0, 1'b1, 200);
		mdl[0] = 16'h0016;
		rd_all();
		$display("set point done");
		btn_up <= 1'b1;
		btn_down <= 1'b1;
		wait_on(1, 1'b1, 10100);
		chk_val(16'(n > 9900), 16'h0001);
		btn_up <= 1'b0;
		btn_down <= 1'b0;
		@(posedge clk_sys);
		wr(sps_pkg::A_CONTROL, 16'h0002);
		rd(sps_pkg::A_STATUS, 16'h00c3);
		btn_down <= 1'b1;
		wait_on(2, 1'b1, 6100);
		chk_val(16'(n > 5900), 16'h0001);
		chk_val({15'h0, cal_dashes}, 16'h0001);
		btn_down <= 1'b0;
		wait_on(3, 1'b0, 20100);
		chk_val(16'(n > 19800), 16'h0001);
		$display("calibration done");
		stop_test();
	end
endmodule
